// ===== pkg/low_power_card_detect_regs.svh
// Register offsets, field positions, reset values and timing counts of the card detect sequencer
// Assumes a 25 MHz system clock and the plain register port of the sequencer
`ifndef LOW_POWER_CARD_DETECT_REGS_SVH
`define LOW_POWER_CARD_DETECT_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_REF_CONFIG 8'h34
`define OFS_FIELD_ON_TIME 8'h36
`define OFS_THRESHOLD 8'h37
`define OFS_REFSRC_CONTROL 8'h38
`define OFS_LEAD_TIME 8'h39
`define OFS_LAG_TIME 8'h3A
`define OFS_MODE_SWITCH 8'h40
`define OFS_STATUS 8'h41
`define OFS_GAIN_REFERENCE 8'h42
`define OFS_LAST_GAIN 8'h43

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SRC_LSB 0
`define SRC_MSB 1
`define SRC_CALIBRATE 2'h0
`define SRC_REGISTER 2'h1
`define CTL_AUX_A_WAKE 2
`define CTL_AUX_B_DETECT 3
`define CTL_AUX_A_SUPPLY 4
`define STS_DETECT 0
`define STS_ACTIVE 1
`define STS_CALIBRATED 2
`define GREF_GEAR_MSB 3
`define GREF_REF_LSB 4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_GEAR 4'h0
`define RST_CTRL 5'h00
`define RST_GAIN_REF 14'h0000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 40
`define FIELD_UNIT_NS 8000
`define OUT_UNIT_NS 5000
`define FIELD_UNIT_CYC (`FIELD_UNIT_NS / `CLK_PERIOD_NS)
`define OUT_UNIT_CYC (`OUT_UNIT_NS / `CLK_PERIOD_NS)

`endif

// ===== pkg/low_power_card_detect_pkg.sv
// Types shared by the card detect sequencer
// Assumes the offsets and counts of low_power_card_detect_regs.svh
package low_power_card_detect_pkg;

  // --------------------------------------------------------------------------
  // Configuration fields: gear, four bytes and control bits
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] gear;
    logic [7:0] field_on_time;
    logic [7:0] threshold;
    logic [4:0] control;
    logic [7:0] lead_time;
    logic [7:0] lag_time;
  } detect_cfg_t;

  // --------------------------------------------------------------------------
  // Analog front end measurement
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [9:0] value;
    logic field_on_done;
  } gain_sense_t;

  // --------------------------------------------------------------------------
  // Sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_STANDBY,
    ST_LEAD,
    ST_FIELD_CMD,
    ST_FIELD,
    ST_LAG
  } detect_state_t;

endpackage

// ===== rtl/low_power_card_detect.sv
// Low-power card detection sequencer: standby timing, field-on measurement, comparison
// Assumes a 25 MHz clock, a same-clock register master and same-clock analog sense inputs
//
// Functional notes
// - Slow oscillator ticks count the wake-up counter down; expiry ends standby.
// - Mode-switch write carries the standby duration loaded into the wake-up counter.
// - Reference comes from the gain reference register or a calibration run.
// - Register-source loops start with standby lasting the commanded duration; calibration measures first.
// - Detection switches the field on for the set time, then compares gain.
// - Gain below the reference by more than the threshold raises the card detect interrupt.
// - Host register settings are never saved nor restored around detection.
// - No detection means no interrupt and a return to standby.
// - Loop ends on detection, reset, host select or external field.
// - Reset stops the loop and restores all configuration defaults.
// - Without power control, type A 106 kbit/s settings apply while sensing.
// - With power control, field-on command runs; timer starts after it finishes.
// - Field stays on field-on-time byte times 8 microseconds.
// - Wake when reference minus current gain exceeds the threshold byte.
// - Gear is bits 3:0 of the reference config; bits 15:4 reserved.
// - Source 00 calibrates then detects, 01 uses register, others reserved.
// - Control bit 2 raises output A on wake-up before the field.
// - Control bit 3 drives output B for the supply on card detect.
// - Control bit 4 drives output A for the supply on wake-up.
// - Output A rises before the transmitter and falls after field off.
// - Output A to field on takes lead byte times 5 microseconds.
// - Field off to output A low takes lag byte times 5 microseconds.
`include "low_power_card_detect_regs.svh"

module low_power_card_detect #(
  parameter int unsigned FIELD_UNIT_CYC = `FIELD_UNIT_CYC,
  parameter int unsigned OUT_UNIT_CYC = `OUT_UNIT_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic slow_oscillator,
  input wire logic host_select_n,
  input wire logic rf_level_detect,
  input wire logic dynamic_power_control,
  input wire low_power_card_detect_pkg::gain_sense_t gain_sense,
  output logic field_enable,
  output logic field_on_command,
  output logic iso_a_settings,
  output logic [3:0] gain_gear_field,
  output logic aux_output_a,
  output logic aux_output_b,
  output logic card_detect_interrupt,
  output logic detect_active
);
  import low_power_card_detect_pkg::*;

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  logic [1:0] osc_sync_r, nss_sync_r, rfl_sync_r;
  logic osc_prev_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      osc_sync_r <= 2'h0;
      nss_sync_r <= 2'h3;
      rfl_sync_r <= 2'h0;
      osc_prev_r <= 1'b0;
    end else begin
      osc_sync_r <= {osc_sync_r[0], slow_oscillator};
      nss_sync_r <= {nss_sync_r[0], host_select_n};
      rfl_sync_r <= {rfl_sync_r[0], rf_level_detect};
      osc_prev_r <= osc_sync_r[1];
    end
  end

  logic osc_tick, stop_req;
  assign osc_tick = osc_sync_r[1] & ~osc_prev_r;
  assign stop_req = ~nss_sync_r[1] | rfl_sync_r[1];
  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  detect_state_t state_r, state_nxt;
  detect_cfg_t cfg_r, cfg_nxt;
  logic [13:0] gref_r, gref_nxt;
  logic [15:0] dur_r, dur_nxt, wake_r, wake_nxt;
  logic [23:0] tmr_r, tmr_nxt;
  logic [9:0] ref_r, ref_nxt, last_r, last_nxt;
  logic calib_r, calib_nxt, calibrated_r, calibrated_nxt;
  logic hit_r, hit_nxt, flag_r, flag_nxt;
  logic field_r, field_nxt, fcmd_r, fcmd_nxt, iso_r, iso_nxt;
  logic [3:0] gear_r, gear_nxt;
  logic aux_a_r, aux_a_nxt, aux_b_r, aux_b_nxt, active_r, active_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic go_measure, go_field, resolve, cmp_hit, aux_a_en;
  assign aux_a_en = cfg_r.control[`CTL_AUX_A_WAKE] | cfg_r.control[`CTL_AUX_A_SUPPLY];
  assign cmp_hit = (ref_r > gain_sense.value) &&
                   ((ref_r - gain_sense.value) > {2'h0, cfg_r.threshold});

  always_comb begin
    state_nxt = state_r;
    cfg_nxt = cfg_r;
    gref_nxt = gref_r;
    dur_nxt = dur_r;
    wake_nxt = wake_r;
    tmr_nxt = tmr_r;
    ref_nxt = ref_r;
    last_nxt = last_r;
    calib_nxt = calib_r;
    calibrated_nxt = calibrated_r;
    hit_nxt = hit_r;
    flag_nxt = flag_r;
    field_nxt = field_r;
    fcmd_nxt = 1'b0;
    iso_nxt = iso_r;
    gear_nxt = gear_r;
    aux_a_nxt = aux_a_r;
    aux_b_nxt = aux_b_r;
    go_measure = 1'b0;
    go_field = 1'b0;
    resolve = 1'b0;
    // Register writes; host settings are simply left as written
    if (reg_wr) begin
      case (reg_addr)
        `OFS_REF_CONFIG: cfg_nxt.gear = reg_wdata[3:0];
        `OFS_FIELD_ON_TIME: cfg_nxt.field_on_time = reg_wdata[7:0];
        `OFS_THRESHOLD: cfg_nxt.threshold = reg_wdata[7:0];
        `OFS_REFSRC_CONTROL: cfg_nxt.control = reg_wdata[4:0];
        `OFS_LEAD_TIME: cfg_nxt.lead_time = reg_wdata[7:0];
        `OFS_LAG_TIME: cfg_nxt.lag_time = reg_wdata[7:0];
        `OFS_GAIN_REFERENCE: gref_nxt = reg_wdata[13:0];
        `OFS_STATUS: flag_nxt = flag_r & ~reg_wdata[`STS_DETECT];
        default: ;
      endcase
    end
    case (state_r)
      ST_IDLE: begin
        if (reg_wr && reg_addr == `OFS_MODE_SWITCH) begin
          dur_nxt = reg_wdata;
          wake_nxt = reg_wdata;
          aux_b_nxt = 1'b0;
          case (cfg_r.control[`SRC_MSB:`SRC_LSB])
            `SRC_CALIBRATE: begin
              gear_nxt = cfg_r.gear;
              calib_nxt = 1'b1;
              go_measure = 1'b1;
            end
            `SRC_REGISTER: begin
              gear_nxt = gref_r[`GREF_GEAR_MSB:0];
              ref_nxt = gref_r[13:`GREF_REF_LSB];
              calibrated_nxt = 1'b1;
              state_nxt = ST_STANDBY;
            end
            default: ;
          endcase
        end
      end
      ST_STANDBY: begin
        if (osc_tick) begin
          if (wake_r <= 16'h0001) begin
            go_measure = 1'b1;
          end else begin
            wake_nxt = wake_r - 16'h0001;
          end
        end
      end
      ST_LEAD: begin
        if (tmr_r == 24'h000000) begin
          go_field = 1'b1;
        end else begin
          tmr_nxt = tmr_r - 24'h000001;
        end
      end
      ST_FIELD_CMD: begin
        if (gain_sense.field_on_done) begin
          tmr_nxt = 24'(32'(cfg_r.field_on_time) * FIELD_UNIT_CYC);
          state_nxt = ST_FIELD;
        end
      end
      ST_FIELD: begin
        if (tmr_r == 24'h000000) begin
          last_nxt = gain_sense.value;
          field_nxt = 1'b0;
          iso_nxt = 1'b0;
          if (calib_r) begin
            ref_nxt = gain_sense.value;
            calib_nxt = 1'b0;
            calibrated_nxt = 1'b1;
            hit_nxt = 1'b0;
          end else begin
            hit_nxt = cmp_hit;
          end
          if (aux_a_r) begin
            tmr_nxt = 24'(32'(cfg_r.lag_time) * OUT_UNIT_CYC);
            state_nxt = ST_LAG;
          end else begin
            resolve = 1'b1;
          end
        end else begin
          tmr_nxt = tmr_r - 24'h000001;
        end
      end
      ST_LAG: begin
        if (tmr_r == 24'h000000) begin
          aux_a_nxt = 1'b0;
          resolve = 1'b1;
        end else begin
          tmr_nxt = tmr_r - 24'h000001;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    // Wake-up: output A ahead of the field when enabled
    if (go_measure) begin
      if (aux_a_en) begin
        aux_a_nxt = 1'b1;
        tmr_nxt = 24'(32'(cfg_r.lead_time) * OUT_UNIT_CYC);
        state_nxt = ST_LEAD;
      end else begin
        go_field = 1'b1;
      end
    end
    if (go_field) begin
      field_nxt = 1'b1;
      if (dynamic_power_control) begin
        fcmd_nxt = 1'b1;
        state_nxt = ST_FIELD_CMD;
      end else begin
        iso_nxt = 1'b1;
        tmr_nxt = 24'(32'(cfg_r.field_on_time) * FIELD_UNIT_CYC);
        state_nxt = ST_FIELD;
      end
    end
    if (resolve) begin
      if (hit_nxt) begin
        flag_nxt = 1'b1;
        aux_b_nxt = cfg_r.control[`CTL_AUX_B_DETECT];
        state_nxt = ST_IDLE;
      end else begin
        wake_nxt = dur_r;
        state_nxt = ST_STANDBY;
      end
    end
    if (stop_req && state_r != ST_IDLE) begin
      state_nxt = ST_IDLE;
      field_nxt = 1'b0;
      fcmd_nxt = 1'b0;
      iso_nxt = 1'b0;
      aux_a_nxt = 1'b0;
      calib_nxt = 1'b0;
    end
    active_nxt = state_nxt != ST_IDLE;
  end

  // --------------------------------------------------------------------------
  // Register read port
  // --------------------------------------------------------------------------
  always_comb begin
    rdata_nxt = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `OFS_REF_CONFIG: rdata_nxt = {12'h000, cfg_r.gear};
        `OFS_FIELD_ON_TIME: rdata_nxt = {8'h00, cfg_r.field_on_time};
        `OFS_THRESHOLD: rdata_nxt = {8'h00, cfg_r.threshold};
        `OFS_REFSRC_CONTROL: rdata_nxt = {11'h000, cfg_r.control};
        `OFS_LEAD_TIME: rdata_nxt = {8'h00, cfg_r.lead_time};
        `OFS_LAG_TIME: rdata_nxt = {8'h00, cfg_r.lag_time};
        `OFS_MODE_SWITCH: rdata_nxt = dur_r;
        `OFS_STATUS: rdata_nxt = {13'h0000, calibrated_r, state_r != ST_IDLE, flag_r};
        `OFS_GAIN_REFERENCE: rdata_nxt = {2'h0, gref_r};
        `OFS_LAST_GAIN: rdata_nxt = {6'h00, last_r};
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  // Reset returns every setting to its default
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cfg_r <= '{`RST_GEAR, `RST_BYTE, `RST_BYTE, `RST_CTRL, `RST_BYTE, `RST_BYTE};
      gref_r <= `RST_GAIN_REF;
      dur_r <= 16'h0000;
      wake_r <= 16'h0000;
      tmr_r <= 24'h000000;
      ref_r <= 10'h000;
      last_r <= 10'h000;
      calib_r <= 1'b0;
      calibrated_r <= 1'b0;
      hit_r <= 1'b0;
      flag_r <= 1'b0;
      field_r <= 1'b0;
      fcmd_r <= 1'b0;
      iso_r <= 1'b0;
      gear_r <= `RST_GEAR;
      aux_a_r <= 1'b0;
      aux_b_r <= 1'b0;
      rdata_r <= 16'h0000;
      active_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cfg_r <= cfg_nxt;
      gref_r <= gref_nxt;
      dur_r <= dur_nxt;
      wake_r <= wake_nxt;
      tmr_r <= tmr_nxt;
      ref_r <= ref_nxt;
      last_r <= last_nxt;
      calib_r <= calib_nxt;
      calibrated_r <= calibrated_nxt;
      hit_r <= hit_nxt;
      flag_r <= flag_nxt;
      field_r <= field_nxt;
      fcmd_r <= fcmd_nxt;
      iso_r <= iso_nxt;
      gear_r <= gear_nxt;
      aux_a_r <= aux_a_nxt;
      aux_b_r <= aux_b_nxt;
      rdata_r <= rdata_nxt;
      active_r <= active_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign field_enable = field_r;
  assign field_on_command = fcmd_r;
  assign iso_a_settings = iso_r;
  assign gain_gear_field = gear_r;
  assign aux_output_a = aux_a_r;
  assign aux_output_b = aux_b_r;
  assign card_detect_interrupt = flag_r;
  assign detect_active = active_r;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  logic [23:0] lead_cyc_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lead_cyc_r <= 24'h000000;
    end else if (state_r == ST_LEAD) begin
      lead_cyc_r <= lead_cyc_r + 24'h000001;
    end else if (state_r == ST_STANDBY || state_r == ST_IDLE) begin
      lead_cyc_r <= 24'h000000;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_wake_expiry: assert property (
    state_r == ST_STANDBY && osc_tick && wake_r <= 16'h0001 && !stop_req
    |=> state_r != ST_STANDBY && state_r != ST_IDLE)
    else $error("standby did not end on counter expiry");
  a_sense_settings: assert property (iso_a_settings |-> field_enable)
    else $error("sensing settings without field");
  a_detect_irq: assert property (resolve && hit_nxt && !stop_req
    |=> card_detect_interrupt && state_r == ST_IDLE)
    else $error("detection raised no interrupt");
  a_miss_standby: assert property (resolve && !hit_nxt && !stop_req
    |=> state_r == ST_STANDBY && !$rose(card_detect_interrupt))
    else $error("miss did not return to standby");
  a_irq_sticky: assert property (
    card_detect_interrupt && !(reg_wr && reg_addr == `OFS_STATUS && reg_wdata[0])
    |=> card_detect_interrupt)
    else $error("interrupt dropped without clear");
  a_stop_idle: assert property (stop_req && state_r != ST_IDLE
    |=> state_r == ST_IDLE && !field_enable && !aux_output_a)
    else $error("stop event did not end the loop");
  a_cmd_wait: assert property (
    state_r == ST_FIELD_CMD && !gain_sense.field_on_done && !stop_req
    |=> state_r == ST_FIELD_CMD)
    else $error("field timer started before command finished");
  a_calib_ref: assert property (
    state_r == ST_FIELD && tmr_r == 24'h000000 && calib_r && !stop_req
    |=> ref_r == $past(gain_sense.value) && calibrated_r)
    else $error("calibration reference not captured");
  a_lead_delay: assert property (
    $rose(field_enable) && aux_output_a
    |-> lead_cyc_r == 24'(32'(cfg_r.lead_time) * OUT_UNIT_CYC) + 24'h000001)
    else $error("output lead time wrong");
  a_aux_b_detect: assert property (
    resolve && hit_nxt && cfg_r.control[3] && !stop_req |=> aux_output_b)
    else $error("output B not driven on detect");
  a_reserved_zero: assert property (
    reg_rd && reg_addr == `OFS_REF_CONFIG |=> reg_rdata[15:4] == 12'h000)
    else $error("reserved reference bits not zero");
  a_aux_before_field: assert property (
    $rose(field_enable) && aux_a_en |-> aux_output_a)
    else $error("output A not high before field");

  c_calibration: cover property (calib_r ##1 !calib_r && calibrated_r);
  c_detect: cover property ($rose(card_detect_interrupt));
  c_miss_loop: cover property (resolve && !hit_nxt);
  c_stop: cover property (stop_req && state_r == ST_FIELD);

endmodule

// ===== verif/frontend_model.sv
// Analog front end and slow oscillator model for the card detect sequencer bench
// Assumes the sequencer clock; answers a field-on command after a fixed delay
module frontend_model #(
  parameter int SLOW_HALF = 10,
  parameter int DONE_DELAY = 5
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic field_enable,
  input wire logic field_on_command,
  input wire logic [9:0] agc_level,
  output logic slow_oscillator,
  output low_power_card_detect_pkg::gain_sense_t gain_sense
);
  timeunit 1ns;
  timeprecision 1ns;
  import low_power_card_detect_pkg::*;
  int slow_cnt = 0;
  int done_cnt;
  logic done_r;
  // --------------------------------------------------------------------------
  // Free running slow oscillator
  // --------------------------------------------------------------------------
  initial slow_oscillator = 1'b0;
  always @(posedge clock) begin
    slow_cnt <= (slow_cnt == SLOW_HALF - 1) ? 0 : slow_cnt + 1;
    if (slow_cnt == SLOW_HALF - 1) begin
      slow_oscillator <= ~slow_oscillator;
    end
  end
  // --------------------------------------------------------------------------
  // Field-on command completion
  // --------------------------------------------------------------------------
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n || !field_enable) begin
      done_cnt <= 0;
      done_r <= 1'b0;
    end else if (field_on_command) begin
      done_cnt <= DONE_DELAY;
    end else if (done_cnt == 1) begin
      done_cnt <= 0;
      done_r <= 1'b1;
    end else if (done_cnt > 1) begin
      done_cnt <= done_cnt - 1;
    end
  end
  // Gain value is only meaningful with the field on
  assign gain_sense = {field_enable ? agc_level : ~agc_level, done_r};
endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the card detect sequencer: register tasks and loop scenarios
// Assumes the front end model on the sense pins and timing units shortened to 2 and 1
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import low_power_card_detect_pkg::*;
  localparam int FU = 2;
  localparam int OU = 1;
  localparam int LIM = 4000;
  logic clock = 1'b0;
  logic rst_n, reg_wr, reg_rd, host_select_n, rf_level_detect, dynamic_power_control;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [9:0] agc_level;
  logic slow_oscillator, field_enable, field_on_command, iso_a_settings;
  logic [3:0] gain_gear_field;
  logic aux_output_a, aux_output_b, card_detect_interrupt, detect_active;
  gain_sense_t gain_sense;
  logic [7:0] raddr [8] = '{8'h34, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3A, 8'h41, 8'h50};
  logic [7:0] cval [5] = '{8'hC3, 8'hA5, 8'h15, 8'h5A, 8'h3C};
  int fails = 0;
  int check_count = 0;
  int ticks = 0;
  int t0 = 0;
  always #20 clock = ~clock;
  always @(posedge slow_oscillator) ticks++;
  low_power_card_detect #(.FIELD_UNIT_CYC(FU), .OUT_UNIT_CYC(OU)) low_power_card_detect_i (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .slow_oscillator(slow_oscillator), .host_select_n(host_select_n),
    .rf_level_detect(rf_level_detect), .dynamic_power_control(dynamic_power_control),
    .gain_sense(gain_sense), .field_enable(field_enable), .field_on_command(field_on_command),
    .iso_a_settings(iso_a_settings), .gain_gear_field(gain_gear_field),
    .aux_output_a(aux_output_a), .aux_output_b(aux_output_b),
    .card_detect_interrupt(card_detect_interrupt), .detect_active(detect_active));
  frontend_model frontend_model_i (
    .clock(clock), .rst_n(rst_n), .field_enable(field_enable),
    .field_on_command(field_on_command), .agc_level(agc_level),
    .slow_oscillator(slow_oscillator), .gain_sense(gain_sense));
  // --------------------------------------------------------------------------
  // Checking and register access
  // --------------------------------------------------------------------------
  task automatic complete_run;
    if (fails == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check16(string name, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_cnt(string name, int exp, int got);
    check_count++;
    if (got != exp) begin
      fails++;
      $display("MISMATCH %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  task automatic reg_write(logic [7:0] a, logic [15:0] wd);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= wd;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(logic [7:0] a, output logic [15:0] rd);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    rd = reg_rdata;
  endtask
  // Mode switch placed just after a slow tick so tick counts are exact
  task automatic start_loop(logic [15:0] dur);
    @(posedge slow_oscillator);
    repeat (3) @(posedge clock);
    t0 = ticks;
    reg_write(8'h40, dur);
  endtask
  // One detection phase: standby ticks, output lead, field time, output lag
  task automatic measure(int e_tk, int e_lead, int e_flen, int e_lag, logic [3:0] e_gear);
    int n, lead, flen, lag, tk, cmd, isob;
    logic [3:0] gear;
    n = 0; lead = 0; flen = 0; lag = 0; cmd = 0; isob = 0;
    @(posedge clock);
    while (field_enable !== 1'b1 && n < LIM) begin
      if (aux_output_a === 1'b1) lead++;
      @(posedge clock);
      n++;
    end
    tk = ticks - t0;
    gear = gain_gear_field;
    while (field_enable === 1'b1 && n < LIM) begin
      flen++;
      if (field_on_command === 1'b1) cmd++;
      if (dynamic_power_control == 1'b0 && iso_a_settings !== 1'b1) isob++;
      @(posedge clock);
      n++;
    end
    while (aux_output_a === 1'b1 && n < LIM) begin
      lag++;
      @(posedge clock);
      n++;
    end
    check_cnt("loop limit", 0, int'(n >= LIM));
    if (e_tk >= 0) check_cnt("standby ticks", e_tk, tk);
    check_cnt("lead cycles", e_lead, lead);
    check_cnt("lag cycles", e_lag, lag);
    check16("gear in use", {12'h000, e_gear}, {12'h000, gear});
    check_cnt("iso settings gaps", 0, isob);
    check_cnt("field commands", int'(dynamic_power_control), cmd);
    if (e_flen > 0) check_cnt("field cycles", e_flen, flen);
    else check_cnt("field cycles in window", 1, int'(flen >= 11 && flen <= 14));
  endtask
  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  initial begin
    #2000000;
    fails++;
    complete_run();
  end
  initial begin
    rst_n = 1'b0; reg_addr = 8'h00; reg_wdata = 16'h0000; reg_wr = 1'b0; reg_rd = 1'b0;
    host_select_n = 1'b1; rf_level_detect = 1'b0; dynamic_power_control = 1'b0;
    agc_level = 10'h000;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    foreach (raddr[i]) begin
      reg_read(raddr[i], d);
      check16("reset or unmapped value", 16'h0000, d);
    end
    foreach (cval[i]) begin
      reg_write(8'h36 + 8'(i), {8'hFF, cval[i]});
      reg_read(8'h36 + 8'(i), d);
      check16("byte register", {8'h00, cval[i]}, d);
    end
    reg_write(8'h34, 16'hFFF5);
    reg_read(8'h34, d);
    check16("gear field", 16'h0005, d & 16'h000F);
    // Register source, card present
    reg_write(8'h36, 16'h0003);
    reg_write(8'h37, 16'h0010);
    reg_write(8'h38, 16'h0009);
    reg_write(8'h42, 16'h2005);
    agc_level <= 10'h100;
    start_loop(16'h0003);
    measure(3, 0, 2 * FU * 3 / 2 + 1, 0, 4'h5);
    repeat (2) @(posedge clock);
    check16("interrupt", 16'h0001, {15'h0000, card_detect_interrupt});
    check16("output b", 16'h0001, {15'h0000, aux_output_b});
    check16("loop active", 16'h0000, {15'h0000, detect_active});
    reg_read(8'h41, d);
    check16("status", 16'h0001, d & 16'h0003);
    reg_read(8'h36, d);
    check16("field time kept", 16'h0003, d);
    reg_read(8'h43, d);
    check16("last gain", 16'h0100, d);
    reg_write(8'h41, 16'h0001);
    @(posedge clock);
    check16("interrupt cleared", 16'h0000, {15'h0000, card_detect_interrupt});
    // Output a timing, gain on the threshold boundary, loop repeats
    reg_write(8'h38, 16'h0015);
    reg_write(8'h39, 16'h0003);
    reg_write(8'h3A, 16'h0002);
    agc_level <= 10'h1F0;
    start_loop(16'h0002);
    measure(2, 3 * OU + 1, 2 * FU * 3 / 2 + 1, 2 * OU + 1, 4'h5);
    check16("output b cleared", 16'h0000, {15'h0000, aux_output_b});
    check16("no interrupt", 16'h0000, {15'h0000, card_detect_interrupt});
    measure(-1, 3 * OU + 1, 2 * FU * 3 / 2 + 1, 2 * OU + 1, 4'h5);
    host_select_n <= 1'b0;
    repeat (4) @(posedge clock);
    check16("select stop", 16'h0000, {14'h0000, detect_active, field_enable});
    host_select_n <= 1'b1;
    // Power control path, stopped by an external field
    dynamic_power_control <= 1'b1;
    reg_write(8'h38, 16'h0001);
    start_loop(16'h0002);
    measure(2, 0, 0, 0, 4'h5);
    rf_level_detect <= 1'b1;
    repeat (4) @(posedge clock);
    check16("field stop", 16'h0000, {14'h0000, detect_active, field_enable});
    rf_level_detect <= 1'b0;
    dynamic_power_control <= 1'b0;
    // Calibration source, then reset in mid loop
    reg_write(8'h34, 16'h0007);
    reg_write(8'h38, 16'h0000);
    agc_level <= 10'h155;
    start_loop(16'h0002);
    measure(0, 0, 2 * FU * 3 / 2 + 1, 0, 4'h7);
    reg_read(8'h41, d);
    check16("reference valid", 16'h0004, d & 16'h0005);
    reg_read(8'h43, d);
    check16("calibration sample", 16'h0155, d);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    check16("reset stop", 16'h0000, {15'h0000, detect_active});
    reg_read(8'h36, d);
    check16("field time default", 16'h0000, d);
    reg_read(8'h42, d);
    check16("reference default", 16'h0000, d);
    // Reserved source code refuses the mode switch
    reg_write(8'h38, 16'h0002);
    reg_write(8'h40, 16'h0002);
    repeat (3) @(posedge clock);
    check16("reserved source", 16'h0000, {14'h0000, detect_active, field_enable});
    complete_run();
  end
endmodule
